/* rtl/pchp_pkg.sv */
// shared constants and types of the slot-port host bus block
package pchp_pkg;

  // ==========================================================================
  // strap layout, captured while reset is held
  localparam int          STRAP_W          = 8;
  localparam int          STRAP_BUS_LSB    = 0;
  localparam int          STRAP_GPIO_BIT   = 3;
  localparam int          STRAP_ORDER_BIT  = 4;
  localparam int          STRAP_POL_BIT    = 5;
  localparam int          STRAP_DIV_LSB    = 6;
  localparam logic [2:0]  BUS_SEP_STROBE   = 3'h4;
  localparam logic [7:0]  STRAP_RESET_VAL  = 8'h00;

  // ==========================================================================
  // host pins and address map
  localparam int          ADDR_W           = 17;
  localparam int          DATA_W           = 16;
  localparam int          CTRL_W           = 5;
  localparam logic [4:0]  CTRL_IDLE_VAL    = 5'h1E;
  localparam logic [17:0] REG_BLOCK_LAST   = 18'h1FFFF;
  localparam logic [17:0] MEM_BLOCK_FIRST  = 18'h20000;
  localparam logic [17:0] MEM_BLOCK_LAST   = 18'h3FFFF;
  localparam logic [16:0] MEM_BUFFER_BYTES = 17'h14000;

  // ==========================================================================
  // bus clock divider
  localparam int          DIV_W            = 2;

  // ==========================================================================
  // access sequencer
  typedef enum logic [1:0] {
    PCHP_IDLE,
    PCHP_REQ,
    PCHP_DONE
  } pchp_state_e;

endpackage

/* rtl/pchp_sync.sv */
// two-stage synchroniser for pins arriving outside core_clk
`timescale 1ns/1ns
module pchp_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* rtl/pchp_clk_div.sv */
// bus clock enable divider, divide 1 to 4
`timescale 1ns/1ns
module pchp_clk_div (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic [pchp_pkg::DIV_W-1:0] div_sel,
  output logic                           bus_clk_en
);

  // ==========================================================================
  // counter wraps at the selected ratio minus one
  logic [pchp_pkg::DIV_W-1:0] cnt_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (cnt_q >= div_sel) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // 00 gives an enable every cycle
  assign bus_clk_en = (cnt_q >= div_sel) && !sys_rst;

endmodule

/* rtl/pchp_host_port.sv */
// slot-port host bus interface: straps, decode, strobes and wait handshake
//
// Notes on behaviour
// - straps are captured at reset release and held until next reset
// - bus type straps 100 enable the separate-strobe 16-bit host port
// - strap three high makes gpio pins inputs, low makes panel outputs
// - strap four picks big endian; strap five picks wait high polarity
// - top two straps set bus clock divide 1, 2, 3 or 4
// - wait stays active until read data valid or write data taken
// - wait is held through internal arbitration; host stretches its cycle
// - memory/register select routes access to registers or display memory
// - offsets 0 to 1FFFF are registers, 20000 to 3FFFF display memory
// - two 128K blocks; display buffer of 80K sits in the second
// - strobes are asynchronous; bus and memory clocks come from input clock
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module pchp_host_port (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  // configuration straps
  input  wire logic [2:0]                  bus_type_straps,
  input  wire logic                        gpio_direction_strap,
  input  wire logic                        byte_order_strap,
  input  wire logic                        hold_polarity_strap,
  input  wire logic [1:0]                  bus_clock_divide_straps,
  // host pins
  input  wire logic                        chip_select_n,
  input  wire logic                        mem_reg_select,
  input  wire logic [pchp_pkg::ADDR_W-1:0] host_address,
  input  wire logic [pchp_pkg::DATA_W-1:0] host_data_in,
  output logic      [pchp_pkg::DATA_W-1:0] host_data_out,
  output logic                             host_data_oe,
  input  wire logic                        read_strobe_n,
  input  wire logic                        low_byte_write_strobe_n,
  input  wire logic                        high_byte_enable_n,
  input  wire logic                        bus_start_in,
  input  wire logic                        read_write_in,
  output logic                             host_wait,
  // configuration seen by the rest of the chip
  output logic                             bus_clk_en,
  output logic                             gpio_as_inputs,
  output logic                             big_endian,
  output logic                             host_port_active,
  // internal access port, toward registers and display memory
  output logic                             int_req,
  output logic                             int_mem_sel,
  output logic      [pchp_pkg::ADDR_W-1:0] int_addr,
  output logic                             int_write,
  output logic      [pchp_pkg::DATA_W-1:0] int_wdata,
  output logic      [1:0]                  int_byte_en,
  input  wire logic                        int_ack,
  input  wire logic [pchp_pkg::DATA_W-1:0] int_rdata
);

  // ==========================================================================
  // helpers
  function automatic logic [15:0] pchp_swap16(input logic [15:0] d, input logic sw);
    pchp_swap16 = sw ? {d[7:0], d[15:8]} : d;
  endfunction

  function automatic logic [1:0] pchp_swap2(input logic [1:0] b, input logic sw);
    pchp_swap2 = sw ? {b[0], b[1]} : b;
  endfunction

  // ==========================================================================
  // synchronisers
  logic [pchp_pkg::STRAP_W-1:0] straps_s;
  logic [pchp_pkg::CTRL_W-1:0]  ctrl_s;
  logic [pchp_pkg::ADDR_W-1:0]  addr_s;
  logic [pchp_pkg::DATA_W-1:0]  data_s;

  pchp_sync #(
    .WIDTH     (pchp_pkg::STRAP_W),
    .RESET_VAL (pchp_pkg::STRAP_RESET_VAL)
  ) u_strap_sync (
    .core_clk (core_clk),
    .sys_rst  (1'b0),
    .async_in ({bus_clock_divide_straps, hold_polarity_strap, byte_order_strap,
                gpio_direction_strap, bus_type_straps}),
    .sync_out (straps_s)
  );

  // strobes and chip select idle high, memory/register select idles low
  pchp_sync #(
    .WIDTH     (pchp_pkg::CTRL_W),
    .RESET_VAL (pchp_pkg::CTRL_IDLE_VAL)
  ) u_ctrl_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({chip_select_n, read_strobe_n, low_byte_write_strobe_n,
                high_byte_enable_n, mem_reg_select}),
    .sync_out (ctrl_s)
  );

  pchp_sync #(
    .WIDTH     (pchp_pkg::ADDR_W),
    .RESET_VAL ('0)
  ) u_addr_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (host_address),
    .sync_out (addr_s)
  );

  pchp_sync #(
    .WIDTH     (pchp_pkg::DATA_W),
    .RESET_VAL ('0)
  ) u_data_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (host_data_in),
    .sync_out (data_s)
  );

  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic hi_s;
  logic msel_s;

  // active-high views of the synchronised pins
  assign cs_s   = ~ctrl_s[4];
  assign rd_s   = ~ctrl_s[3];
  assign wr_s   = ~ctrl_s[2];
  assign hi_s   = ~ctrl_s[1];
  assign msel_s = ctrl_s[0];

  // ==========================================================================
  // strap capture
  // sampled every cycle under reset so the last value before release sticks
  logic [pchp_pkg::STRAP_W-1:0] cfg_q;
  logic                         active_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_q <= straps_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      active_q <= 1'b0;
    end else begin
      active_q <= cfg_q[pchp_pkg::STRAP_BUS_LSB +: 3] == pchp_pkg::BUS_SEP_STROBE;
    end
  end

  assign host_port_active = active_q;
  assign gpio_as_inputs   = cfg_q[pchp_pkg::STRAP_GPIO_BIT];
  assign big_endian       = cfg_q[pchp_pkg::STRAP_ORDER_BIT];

  // ==========================================================================
  // bus clock, memory side shares the same enable
  pchp_clk_div u_div (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .div_sel    (cfg_q[pchp_pkg::STRAP_DIV_LSB +: pchp_pkg::DIV_W]),
    .bus_clk_en (bus_clk_en)
  );

  // ==========================================================================
  // cycle detection in the bus clock
  logic access_s;
  logic prev_q;
  logic start;

  // bus start and direction pins are tied high and carry nothing here
  // wait asserts already in idle, so the host keeps its strobe until the enable comes
  // limitation: a strobe that drops before the next enable is never seen
  assign access_s = active_q && cs_s && (rd_s || wr_s);
  assign start    = bus_clk_en && access_s && !prev_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
    end else if (bus_clk_en) begin
      prev_q <= access_s;
    end
  end

  // ==========================================================================
  // decode of the captured access
  logic [17:0] offset;
  logic        beyond_buffer;
  logic        is_mem;

  assign offset        = {msel_s, addr_s};
  assign is_mem        = (offset >= pchp_pkg::MEM_BLOCK_FIRST) && (offset <= pchp_pkg::MEM_BLOCK_LAST);
  // upper part of the memory block has no storage behind it
  assign beyond_buffer = is_mem && (addr_s >= pchp_pkg::MEM_BUFFER_BYTES);

  // ==========================================================================
  // access sequencer
  pchp_pkg::pchp_state_e state_q;
  logic                  ack_seen_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= pchp_pkg::PCHP_IDLE;
    end else begin
      case (state_q)
        pchp_pkg::PCHP_IDLE: begin
          if (start) begin
            state_q <= beyond_buffer ? pchp_pkg::PCHP_DONE : pchp_pkg::PCHP_REQ;
          end
        end
        pchp_pkg::PCHP_REQ: begin
          if (bus_clk_en && (ack_seen_q || int_ack)) begin
            state_q <= pchp_pkg::PCHP_DONE;
          end
        end
        pchp_pkg::PCHP_DONE: begin
          if (bus_clk_en && !access_s) begin
            state_q <= pchp_pkg::PCHP_IDLE;
          end
        end
        default: begin
          state_q <= pchp_pkg::PCHP_IDLE;
        end
      endcase
    end
  end

  // ack may land between bus enables, so it is held
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ack_seen_q <= 1'b0;
    end else if (state_q == pchp_pkg::PCHP_REQ && int_ack) begin
      ack_seen_q <= 1'b1;
    end else if (state_q != pchp_pkg::PCHP_REQ) begin
      ack_seen_q <= 1'b0;
    end
  end

  // ==========================================================================
  // internal request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      int_req <= 1'b0;
    end else if (state_q == pchp_pkg::PCHP_IDLE && start && !beyond_buffer) begin
      int_req <= 1'b1;
    end else if (int_ack) begin
      int_req <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      int_mem_sel <= 1'b0;
      int_addr    <= '0;
      int_write   <= 1'b0;
      int_wdata   <= '0;
      int_byte_en <= 2'h0;
    end else if (state_q == pchp_pkg::PCHP_IDLE && start) begin
      int_mem_sel <= is_mem;
      int_addr    <= addr_s;
      int_write   <= wr_s;
      int_wdata   <= pchp_swap16(data_s, big_endian);
      // high strobe alone with odd address is the upper byte only
      int_byte_en <= pchp_swap2({hi_s, !(hi_s && addr_s[0])}, big_endian);
    end
  end

  // ==========================================================================
  // read data toward the host
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      host_data_out <= '0;
    end else if (state_q == pchp_pkg::PCHP_IDLE && start && beyond_buffer) begin
      host_data_out <= '0;
    end else if (state_q == pchp_pkg::PCHP_REQ && int_ack && !ack_seen_q) begin
      host_data_out <= pchp_swap16(int_rdata, big_endian);
    end
  end

  // lanes are driven only once the data are settled
  assign host_data_oe = (state_q == pchp_pkg::PCHP_DONE) && !int_write && cs_s && rd_s;

  // ==========================================================================
  // wait handshake
  // wait asserts only after the synchroniser delay, from the synchronised strobes, so a slow bus clock lengthens every access
  // push-pull pin with no enable; the board pull-up only speeds the release edge
  logic wait_active;

  assign wait_active = (state_q == pchp_pkg::PCHP_REQ)
                     || (state_q == pchp_pkg::PCHP_IDLE && access_s);
  assign host_wait   = cfg_q[pchp_pkg::STRAP_POL_BIT] ? wait_active : !wait_active;

endmodule

/* dv/pchp_host_port_sva.sv */
// assertions on the slot-port host bus block ports
`timescale 1ns/1ns
module pchp_host_port_sva (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [2:0]  bus_type_straps,
  input wire logic        hold_polarity_strap,
  input wire logic [1:0]  bus_clock_divide_straps,
  input wire logic        mem_reg_select,
  input wire logic [16:0] host_address,
  input wire logic        read_strobe_n,
  input wire logic        low_byte_write_strobe_n,
  input wire logic        high_byte_enable_n,
  input wire logic        host_data_oe,
  input wire logic        host_wait,
  input wire logic        bus_clk_en,
  input wire logic        gpio_as_inputs,
  input wire logic        big_endian,
  input wire logic        host_port_active,
  input wire logic        int_req,
  input wire logic        int_mem_sel,
  input wire logic [16:0] int_addr,
  input wire logic        int_write,
  input wire logic [1:0]  int_byte_en,
  input wire logic        int_ack
);
  // ==========
  // helpers
  wire logic  hi_w = !high_byte_enable_n;
  wire logic  lo_w = !(hi_w && host_address[0]);
  logic [1:0] gap_q;
  logic       seen_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // first pulse after release has no reference spacing
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gap_q  <= 2'h0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= bus_clk_en ? 2'h0 : gap_q + 2'h1;
      seen_q <= seen_q | bus_clk_en;
    end
  end

  // ==========
  // properties
  sequence s_ack;
    int_req && int_ack;
  endsequence
  sequence s_free;
    ##[1:8] host_wait != hold_polarity_strap;
  endsequence
  sequence s_rd_ack;
    int_req && int_ack && !int_write;
  endsequence

  AST_REQ_HOLD: assert property (int_req && !int_ack |=> int_req)
    else $error("request dropped before grant");
  AST_REQ_END: assert property (s_ack |=> !int_req)
    else $error("request kept after grant");
  AST_WAIT_ON: assert property (int_req |-> host_wait == hold_polarity_strap)
    else $error("wait inactive while request open");
  AST_WAIT_OFF: assert property (s_ack |-> s_free)
    else $error("wait not released after grant");
  AST_PORT_ON: assert property ($fell(sys_rst) |=> host_port_active == (bus_type_straps == 3'h4))
    else $error("port enable wrong after release");
  AST_CFG_HOLD: assert property (!$past(sys_rst) |-> $stable({gpio_as_inputs, big_endian}))
    else $error("configuration moved outside reset");
  AST_DIV: assert property (bus_clk_en && seen_q |-> gap_q == bus_clock_divide_straps)
    else $error("bus clock spacing wrong");
  AST_FIELDS: assert property ($rose(int_req) |-> int_mem_sel == mem_reg_select && int_addr == host_address
                               && int_write == !low_byte_write_strobe_n)
    else $error("request fields differ from pins");
  AST_LANES: assert property ($rose(int_req) |-> int_byte_en == (big_endian ? {lo_w, hi_w} : {hi_w, lo_w}))
    else $error("byte enables wrong");
  AST_BUFFER: assert property (int_req && int_mem_sel |-> int_addr < 17'h14000)
    else $error("memory request past buffer end");
  AST_OE: assert property (host_data_oe |-> !$past(read_strobe_n, 2))
    else $error("data driven without read");
  AST_OE_ON: assert property (s_rd_ack |-> ##[1:8] host_data_oe)
    else $error("read data not driven after grant");
endmodule

bind pchp_host_port pchp_host_port_sva u_sva (
  .core_clk, .sys_rst, .bus_type_straps, .hold_polarity_strap, .bus_clock_divide_straps, .mem_reg_select,
  .host_address, .read_strobe_n, .low_byte_write_strobe_n, .high_byte_enable_n, .host_data_oe, .host_wait,
  .bus_clk_en, .gpio_as_inputs, .big_endian, .host_port_active, .int_req, .int_mem_sel, .int_addr,
  .int_write, .int_byte_en, .int_ack
);

/* dv/pchp_host_model.sv */
// slot controller model driving the separate-strobe host pins
`timescale 1ns/1ns
module pchp_host_model (
  input  wire logic        core_clk,
  input  wire logic        pol,
  input  wire logic        host_wait,
  input  wire logic [15:0] host_data_out,
  output logic             chip_select_n,
  output logic             mem_reg_select,
  output logic [16:0]      host_address,
  output logic [15:0]      host_data_in,
  output logic             read_strobe_n,
  output logic             low_byte_write_strobe_n,
  output logic             high_byte_enable_n
);
  logic        wait_s;
  logic [15:0] rd_s;

  initial begin
    {chip_select_n, read_strobe_n, low_byte_write_strobe_n, high_byte_enable_n} = 4'hF;
    mem_reg_select = 1'b0;
    host_address   = 17'h00000;
    host_data_in   = 16'h0000;
  end

  // sampled at the edge so reads never race the design flops
  always @(posedge core_clk) begin
    wait_s <= host_wait;
    rd_s   <= host_data_out;
  end

  // ==========
  // one access, stretched while wait stands
  task automatic access(input logic wr, input logic ms, input logic [16:0] a, input logic hi,
                        input logic [15:0] wd, output logic [15:0] rd);
    @(posedge core_clk);
    chip_select_n           <= 1'b0;
    mem_reg_select          <= ms;
    host_address            <= a;
    high_byte_enable_n      <= !hi;
    host_data_in            <= wr ? wd : ~host_data_in;
    read_strobe_n           <= wr;
    low_byte_write_strobe_n <= !wr;
    repeat (4) @(posedge core_clk);
    #1;
    // a wait that never ends is left to the bench watchdog, which counts it
    while (wait_s === pol) begin
      @(posedge core_clk);
      #1;
    end
    rd = rd_s;
    @(posedge core_clk);
    {chip_select_n, read_strobe_n, low_byte_write_strobe_n, high_byte_enable_n} <= 4'hF;
    // released lines show the inverse, never a stale value
    host_data_in <= ~host_data_in;
    repeat (10) @(posedge core_clk);
  endtask
endmodule

/* dv/pchp_host_port_tb_top.sv */
// self-checking bench of the slot-port host bus block
`timescale 1ns/1ns
module pchp_host_port_tb_top;
  // ==========
  // signals
  logic        core_clk, sys_rst, gpio_direction_strap, byte_order_strap, hold_polarity_strap;
  logic [2:0]  bus_type_straps;
  logic [1:0]  bus_clock_divide_straps, int_byte_en;
  logic        chip_select_n, mem_reg_select, read_strobe_n, low_byte_write_strobe_n, high_byte_enable_n;
  logic [16:0] host_address, int_addr;
  logic [15:0] host_data_in, host_data_out, int_wdata, int_rdata, rd;
  logic        host_data_oe, host_wait, bus_clk_en, gpio_as_inputs, big_endian, host_port_active;
  logic        int_req, int_mem_sel, int_write, int_ack;
  logic [36:0] cap;
  int          n_fail, total_checks, n_ack, dly, ack_dly;

  pchp_host_port u_dut (
    .core_clk, .sys_rst, .bus_type_straps, .gpio_direction_strap, .byte_order_strap, .hold_polarity_strap,
    .bus_clock_divide_straps, .chip_select_n, .mem_reg_select, .host_address, .host_data_in, .host_data_out,
    .host_data_oe, .read_strobe_n, .low_byte_write_strobe_n, .high_byte_enable_n,
    .bus_start_in(1'b1), .read_write_in(1'b1),
    .host_wait, .bus_clk_en, .gpio_as_inputs, .big_endian, .host_port_active, .int_req, .int_mem_sel,
    .int_addr, .int_write, .int_wdata, .int_byte_en, .int_ack, .int_rdata
  );

  pchp_host_model u_host (
    .core_clk, .pol(hold_polarity_strap), .host_wait, .host_data_out, .chip_select_n, .mem_reg_select,
    .host_address, .host_data_in, .read_strobe_n, .low_byte_write_strobe_n, .high_byte_enable_n
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ==========
  // internal arbiter; slow grants stand in for refresh contention
  always @(posedge core_clk) begin
    if (int_req && !int_ack && dly >= ack_dly) begin
      int_ack <= 1'b1;
      n_ack   <= n_ack + 1;
      cap     <= {int_mem_sel, int_write, int_byte_en, int_addr, int_wdata};
    end else begin
      int_ack <= 1'b0;
    end
    dly <= int_req ? dly + 1 : 0;
  end

  // ==========
  // tasks
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic boot(input logic [7:0] s);
    int g;
    {bus_clock_divide_straps, hold_polarity_strap, byte_order_strap, gpio_direction_strap, bus_type_straps} <= s;
    sys_rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("active", host_port_active, s[2:0] == 3'h4);
    chk("config", {gpio_as_inputs, big_endian}, {s[3], s[4]});
    g = 0;
    while (bus_clk_en !== 1'b1 && g < 9) begin
      @(posedge core_clk);
      #1;
      g++;
    end
    g = 0;
    do begin
      @(posedge core_clk);
      #1;
      g++;
    end while (bus_clk_en !== 1'b1 && g < 9);
    chk("divide", g, s[7:6] + 3'h1);
  endtask

  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========
  // sequence
  initial begin
    {n_fail, total_checks, n_ack, dly, ack_dly} = '0;
    int_ack   = 1'b0;
    int_rdata = 16'h0000;
    sys_rst   = 1'b1;
    boot(8'h4C);
    u_host.access(1'b1, 1'b0, 17'h00020, 1'b1, 16'hA1B2, rd);
    chk("reg write", cap, {4'h7, 17'h00020, 16'hA1B2});
    ack_dly   <= 12;
    int_rdata <= 16'h5A3C;
    u_host.access(1'b0, 1'b1, 17'h13FFE, 1'b1, 16'h0000, rd);
    chk("mem read", rd, 16'h5A3C);
    chk("mem fields", cap[36:16], {4'hB, 17'h13FFE});
    u_host.access(1'b0, 1'b0, 17'h1FFFF, 1'b0, 16'h0000, rd);
    chk("byte fields", cap[36:16], {4'h1, 17'h1FFFF});
    u_host.access(1'b0, 1'b1, 17'h14000, 1'b1, 16'h0000, rd);
    chk("beyond buffer", rd, 16'h0000);
    chk("grants", n_ack, 3);
    ack_dly <= 0;
    boot(8'hF4);
    @(posedge core_clk);
    byte_order_strap     <= 1'b0;
    gpio_direction_strap <= 1'b1;
    u_host.access(1'b1, 1'b0, 17'h00010, 1'b0, 16'h1234, rd);
    chk("swapped", cap, {4'h6, 17'h00010, 16'h3412});
    chk("held", {gpio_as_inputs, big_endian}, 2'h1);
    u_host.access(1'b0, 1'b0, 17'h00010, 1'b1, 16'h0000, rd);
    chk("swapped read", rd, 16'h3C5A);
    boot(8'h04);
    u_host.access(1'b0, 1'b0, 17'h00003, 1'b1, 16'h0000, rd);
    chk("fast read", rd, 16'h5A3C);
    chk("odd fields", cap[36:16], {4'h2, 17'h00003});
    boot(8'h80);
    u_host.access(1'b1, 1'b0, 17'h00004, 1'b1, 16'h5555, rd);
    chk("off port", n_ack, 6);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    test_done();
  end
endmodule
